// ---- src/phy_mii_carrier_link_timing.sv ----
// mii carrier sense, collision, receive and transmit latency timing with 10BASE-T link integrity
//
// Overview of operation
// - mii interface delays are set in tenths of bit times of 10 ns each and counted in ref_clk cycles
// - 10BASE-T link drops after 50 to 150 ms without pulses or activity
// - link pulses closer than the 2 to 7 ms minimum window are invalid
// - a gap beyond the 50 to 150 ms maximum window restarts pulse qualification
// - receive data and data valid follow carrier sense by 3 to 5 bit times
// - carrier sense rises 12 to 16 bit times after start of J
// - twisted pair carrier sense falls 10 to 17 bit times after start of T
// - fibre carrier sense falls 16 to 22 bit times after start of T
// - twisted pair collision rises 16 to 22 bit times after J while sending
// - fibre collision rises 10 to 15 bit times after J while sending
// - twisted pair collision falls 17 to 20 bit times after start of T
// - fibre collision falls 14 to 18 bit times after start of T
// - twisted pair carrier sense rises 20 to 24 bit times after transmit enable
// - fibre carrier sense rises 17 to 20 bit times after transmit enable
// - twisted pair carrier sense falls 24 to 28 bit times after transmit enable drops
// - fibre carrier sense falls 22 to 24 bit times after transmit enable drops
// - twisted pair line output starts 5.3 to 5.7 bit times after transmit enable
// - fibre line output starts 5 to 5.3 bit times after transmit enable
`timescale 1ns/1ns
`include "phy_timing_regs.svh"
module phy_mii_carrier_link_timing #(
  parameter int DLY_W         = 6,
  parameter int LOSS_CYC      = `MS_CYC(`LINK_LOSS_MS),
  parameter int RX_MIN_CYC    = `MS_CYC(`LINK_RX_MIN_MS),
  parameter int RX_MAX_CYC    = `MS_CYC(`LINK_RX_MAX_MS),
  parameter int TX_PERIOD_CYC = `MS_CYC(`LINK_TX_PERIOD_MS),
  parameter int GOOD_PULSES   = `LINK_GOOD_PULSES
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_b,
  input  wire logic                     tx_clk,
  input  wire logic                     tx_en,
  input  wire logic                     mode_fx,
  input  wire logic                     mode_10bt,
  input  wire logic                     full_duplex,
  input  wire phy_timing_pkg::line_rx_t line_rx,
  input  wire logic                     link_pulse_in,
  input  wire logic                     rx_activity,
  output phy_timing_pkg::mii_rx_t       mii_rx,
  output logic                          line_transmit_output,
  output logic                          link_pulse_out,
  output logic                          link_up
);

  localparam int NEV = phy_timing_pkg::EV_COUNT;

  // target delays in ref_clk cycles, derived from bit times
  localparam int C_DV        = `BT10_CYC(`CRS_TO_DV_BT10);
  localparam int C_J_CRS     = `BT10_CYC(`J_TO_CRS_BT10);
  localparam int C_T_CRS_TP  = `BT10_CYC(`T_TO_CRS_TP_BT10);
  localparam int C_T_CRS_FX  = `BT10_CYC(`T_TO_CRS_FX_BT10);
  localparam int C_J_COL_TP  = `BT10_CYC(`J_TO_COL_TP_BT10);
  localparam int C_J_COL_FX  = `BT10_CYC(`J_TO_COL_FX_BT10);
  localparam int C_T_COL_TP  = `BT10_CYC(`T_TO_COL_TP_BT10);
  localparam int C_T_COL_FX  = `BT10_CYC(`T_TO_COL_FX_BT10);
  localparam int C_TX_CRS_TP = `BT10_CYC(`TXEN_CRS_TP_BT10);
  localparam int C_TX_CRS_FX = `BT10_CYC(`TXEN_CRS_FX_BT10);
  localparam int C_TX_OFF_TP = `BT10_CYC(`TXOFF_CRS_TP_BT10);
  localparam int C_TX_OFF_FX = `BT10_CYC(`TXOFF_CRS_FX_BT10);
  localparam int C_LINE_TP   = `BT10_CYC(`TXEN_LINE_TP_BT10);
  localparam int C_LINE_FX   = `BT10_CYC(`TXEN_LINE_FX_BT10);
  // the same figures less one, as assertion delay bounds
  localparam int A_J_CRS     = C_J_CRS - 1;
  localparam int A_T_CRS_TP  = C_T_CRS_TP - 1;
  localparam int A_T_CRS_FX  = C_T_CRS_FX - 1;
  localparam int A_J_COL_TP  = C_J_COL_TP - 1;
  localparam int A_J_COL_FX  = C_J_COL_FX - 1;
  localparam int A_T_COL_TP  = C_T_COL_TP - 1;
  localparam int A_T_COL_FX  = C_T_COL_FX - 1;
  localparam int A_TX_CRS_TP = C_TX_CRS_TP - 1;
  localparam int A_TX_CRS_FX = C_TX_CRS_FX - 1;
  localparam int A_TX_OFF_TP = C_TX_OFF_TP - 1;
  localparam int A_TX_OFF_FX = C_TX_OFF_FX - 1;
  localparam int A_LINE_TP   = C_LINE_TP - 1;
  localparam int A_LINE_FX   = C_LINE_FX - 1;

  if (C_TX_OFF_TP >= (1 << DLY_W) || C_J_CRS + C_DV >= (1 << DLY_W)) begin : g_bad_width
    $error("DLY_W too narrow for the longest delay");
  end

  logic             txen_link_q;
  logic [4:0]       sync1_q, sync2_q;
  logic             txen_prev_q;
  logic             fx_s, bt10_s, fdx_s, txen_s, lp_s, act_s;
  logic             tx_rise, tx_fall, j_go, t_go;
  logic [NEV-1:0]   ev_start, ev_done;
  logic [DLY_W-1:0] ev_dly [NEV];
  logic             rx_crs_q, rx_crs_d, tx_crs_q, tx_crs_d;
  logic             col_q, col_d, dv_q, dv_d, crs_q, crs_d, line_q, line_d;
  logic [3:0]       rxd_q, rxd_d;

  // link domain: transmit enable as the mac drives it on tx_clk
  always_ff @(posedge tx_clk or negedge rst_b) begin
    if (!rst_b) begin
      txen_link_q <= 1'h0;
    end else begin
      txen_link_q <= tx_en;
    end
  end

  // two flop synchronisers for the straps and the tx_clk level
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      txen_prev_q <= 1'h0;
    end else begin
      sync1_q     <= {mode_fx, mode_10bt, full_duplex, txen_link_q, 1'h0};
      sync2_q     <= {sync1_q[4:1], 1'h0};
      txen_prev_q <= sync2_q[1];
    end
  end

  // link pulse and activity pins take their own pair of flops
  logic [1:0] pin1_q, pin2_q;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin1_q <= '0;
      pin2_q <= '0;
    end else begin
      pin1_q <= {link_pulse_in, rx_activity};
      pin2_q <= pin1_q;
    end
  end

  assign fx_s    = sync2_q[4];
  assign bt10_s  = sync2_q[3];
  assign fdx_s   = sync2_q[2];
  assign txen_s  = sync2_q[1];
  assign lp_s    = pin2_q[1];
  assign act_s   = pin2_q[0];
  assign tx_rise = txen_s & ~txen_prev_q & ~bt10_s;
  assign tx_fall = ~txen_s & txen_prev_q & ~bt10_s;
  assign j_go    = line_rx.j_start & ~bt10_s;
  assign t_go    = line_rx.t_start & ~bt10_s;

  // event starts and mode dependent delays, each less one for the output flop
  always_comb begin
    ev_start = '0;
    ev_start[phy_timing_pkg::EV_RX_CRS_ON]  = j_go;
    ev_start[phy_timing_pkg::EV_RX_DV_ON]   = j_go;
    ev_start[phy_timing_pkg::EV_RX_CRS_OFF] = t_go;
    ev_start[phy_timing_pkg::EV_COL_ON]     = j_go & txen_s & ~fdx_s;
    ev_start[phy_timing_pkg::EV_COL_OFF]    = t_go;
    ev_start[phy_timing_pkg::EV_TX_CRS_ON]  = tx_rise;
    ev_start[phy_timing_pkg::EV_TX_CRS_OFF] = tx_fall;
    ev_start[phy_timing_pkg::EV_LINE_ON]    = tx_rise;
    ev_start[phy_timing_pkg::EV_LINE_OFF]   = tx_fall;
    ev_dly[phy_timing_pkg::EV_RX_CRS_ON]  = DLY_W'(C_J_CRS - 1);
    ev_dly[phy_timing_pkg::EV_RX_DV_ON]   = DLY_W'(C_J_CRS + C_DV - 1);
    ev_dly[phy_timing_pkg::EV_RX_CRS_OFF] = DLY_W'(fx_s ? C_T_CRS_FX - 1 : C_T_CRS_TP - 1);
    ev_dly[phy_timing_pkg::EV_COL_ON]     = DLY_W'(fx_s ? C_J_COL_FX - 1 : C_J_COL_TP - 1);
    ev_dly[phy_timing_pkg::EV_COL_OFF]    = DLY_W'(fx_s ? C_T_COL_FX - 1 : C_T_COL_TP - 1);
    ev_dly[phy_timing_pkg::EV_TX_CRS_ON]  = DLY_W'(fx_s ? C_TX_CRS_FX - 1 : C_TX_CRS_TP - 1);
    ev_dly[phy_timing_pkg::EV_TX_CRS_OFF] = DLY_W'(fx_s ? C_TX_OFF_FX - 1 : C_TX_OFF_TP - 1);
    ev_dly[phy_timing_pkg::EV_LINE_ON]    = DLY_W'(fx_s ? C_LINE_FX - 1 : C_LINE_TP - 1);
    ev_dly[phy_timing_pkg::EV_LINE_OFF]   = DLY_W'(fx_s ? C_LINE_FX - 1 : C_LINE_TP - 1);
  end

  // one delay line per event
  for (genvar i = 0; i < NEV; i++) begin : g_ev
    event_delay #(
      .DLY_W (DLY_W)
    ) u_dly (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .start   (ev_start[i]),
      .dly     (ev_dly[i]),
      .done    (ev_done[i])
    );
  end

  // carrier, collision, line drive and rising data valid follow the delayed events; data valid falls on t_go
  always_comb begin
    rx_crs_d = rx_crs_q;
    tx_crs_d = tx_crs_q;
    col_d    = col_q;
    dv_d     = dv_q;
    line_d   = line_q;
    if (ev_done[phy_timing_pkg::EV_RX_CRS_OFF]) rx_crs_d = 1'h0;
    if (ev_done[phy_timing_pkg::EV_RX_CRS_ON])  rx_crs_d = 1'h1;
    if (t_go)                                   dv_d     = 1'h0;
    if (ev_done[phy_timing_pkg::EV_RX_DV_ON])   dv_d     = 1'h1;
    if (ev_done[phy_timing_pkg::EV_COL_OFF])    col_d    = 1'h0;
    if (ev_done[phy_timing_pkg::EV_COL_ON])     col_d    = 1'h1;
    if (ev_done[phy_timing_pkg::EV_TX_CRS_OFF]) tx_crs_d = 1'h0;
    if (ev_done[phy_timing_pkg::EV_TX_CRS_ON])  tx_crs_d = 1'h1;
    if (ev_done[phy_timing_pkg::EV_LINE_OFF])   line_d   = 1'h0;
    if (ev_done[phy_timing_pkg::EV_LINE_ON])    line_d   = 1'h1;
    if (bt10_s) begin
      rx_crs_d = 1'h0;
      tx_crs_d = 1'h0;
      col_d    = 1'h0;
      dv_d     = 1'h0;
      line_d   = 1'h0;
    end
    crs_d = rx_crs_d | tx_crs_d;
    rxd_d = dv_d ? line_rx.nibble : 4'h0;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_crs_q <= 1'h0;
      tx_crs_q <= 1'h0;
      col_q    <= 1'h0;
      dv_q     <= 1'h0;
      crs_q    <= 1'h0;
      line_q   <= 1'h0;
      rxd_q    <= 4'h0;
    end else begin
      rx_crs_q <= rx_crs_d;
      tx_crs_q <= tx_crs_d;
      col_q    <= col_d;
      dv_q     <= dv_d;
      crs_q    <= crs_d;
      line_q   <= line_d;
      rxd_q    <= rxd_d;
    end
  end

  assign mii_rx.crs           = crs_q;
  assign mii_rx.col           = col_q;
  assign mii_rx.rx_dv         = dv_q;
  assign mii_rx.rxd           = rxd_q;
  assign line_transmit_output = line_q;

  // 10BASE-T link integrity
  link_integrity #(
    .LOSS_CYC      (LOSS_CYC),
    .RX_MIN_CYC    (RX_MIN_CYC),
    .RX_MAX_CYC    (RX_MAX_CYC),
    .TX_PERIOD_CYC (TX_PERIOD_CYC),
    .GOOD_PULSES   (GOOD_PULSES)
  ) u_link (
    .ref_clk        (ref_clk),
    .rst_b          (rst_b),
    .enable         (bt10_s),
    .lp_seen        (lp_s),
    .activity       (act_s),
    .tx_busy        (txen_s),
    .link_up        (link_up),
    .link_pulse_out (link_pulse_out)
  );

  a_rx_crs_on: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (j_go && !rx_crs_q) |-> ##A_J_CRS !rx_crs_q ##1 rx_crs_q)
    else $error("carrier sense not on time after J");
  a_rx_dv_lag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ($rose(rx_crs_q) && !bt10_s) |-> !dv_q[*8] ##1 dv_q)
    else $error("data valid not 8 cycles after carrier sense");
  a_rx_crs_off_tp: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (t_go && !fx_s && rx_crs_q) |-> ##A_T_CRS_TP rx_crs_q ##1 !rx_crs_q)
    else $error("twisted pair carrier sense not off on time");
  a_rx_crs_off_fx: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (t_go && fx_s && rx_crs_q) |-> ##A_T_CRS_FX rx_crs_q ##1 !rx_crs_q)
    else $error("fibre carrier sense not off on time");
  a_col_on_tp: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (j_go && txen_s && !fdx_s && !fx_s && !col_q) |-> ##A_J_COL_TP !col_q ##1 col_q)
    else $error("twisted pair collision not on time");
  a_col_on_fx: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (j_go && txen_s && !fdx_s && fx_s && !col_q) |-> ##A_J_COL_FX !col_q ##1 col_q)
    else $error("fibre collision not on time");
  a_col_off_tp: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (t_go && !fx_s && col_q) |-> ##A_T_COL_TP col_q ##1 !col_q)
    else $error("twisted pair collision not released on time");
  a_col_off_fx: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (t_go && fx_s && col_q) |-> ##A_T_COL_FX col_q ##1 !col_q)
    else $error("fibre collision not released on time");
  a_tx_crs_on_tp: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tx_rise && !fx_s && !tx_crs_q) |-> ##A_TX_CRS_TP !tx_crs_q ##1 tx_crs_q)
    else $error("twisted pair loopback carrier not on time");
  a_tx_crs_on_fx: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tx_rise && fx_s && !tx_crs_q) |-> ##A_TX_CRS_FX !tx_crs_q ##1 tx_crs_q)
    else $error("fibre loopback carrier not on time");
  a_tx_crs_off_tp: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tx_fall && !fx_s && tx_crs_q) |-> ##A_TX_OFF_TP tx_crs_q ##1 !tx_crs_q)
    else $error("twisted pair loopback carrier not off on time");
  a_tx_crs_off_fx: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tx_fall && fx_s && tx_crs_q) |-> ##A_TX_OFF_FX tx_crs_q ##1 !tx_crs_q)
    else $error("fibre loopback carrier not off on time");
  a_line_on_tp: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tx_rise && !fx_s && !line_q) |-> ##A_LINE_TP !line_q ##1 line_q)
    else $error("twisted pair line output late or early");
  a_line_on_fx: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tx_rise && fx_s && !line_q) |-> ##A_LINE_FX !line_q ##1 line_q)
    else $error("fibre line output late or early");

endmodule : phy_mii_carrier_link_timing

// ---- src/phy_timing_regs.svh ----
// timing constants of the mii carrier, collision and link integrity logic
`ifndef PHY_TIMING_REGS_SVH
`define PHY_TIMING_REGS_SVH

// clock and bit time, in ps
`define BIT_TIME_PS        10000
`define REF_CLK_PS         4000
// least delay in tenths of bit times to ref_clk cycles, rounded up
`define BT10_CYC(bt10)     ((((bt10) * `BIT_TIME_PS / 10) + `REF_CLK_PS - 1) / `REF_CLK_PS)
// milliseconds and nanoseconds to ref_clk cycles
`define MS_CYC(ms)         ((ms) * (1000000000 / `REF_CLK_PS))
`define NS_CYC(ns)         ((((ns) * 1000) + `REF_CLK_PS - 1) / `REF_CLK_PS)

// 100 Mb/s receive delays, tenths of bit times
`define CRS_TO_DV_BT10     30
`define J_TO_CRS_BT10      120
`define T_TO_CRS_TP_BT10   100
`define T_TO_CRS_FX_BT10   160
`define J_TO_COL_TP_BT10   160
`define J_TO_COL_FX_BT10   100
`define T_TO_COL_TP_BT10   170
`define T_TO_COL_FX_BT10   140
// 100 Mb/s transmit delays, tenths of bit times
`define TXEN_CRS_TP_BT10   200
`define TXEN_CRS_FX_BT10   170
`define TXOFF_CRS_TP_BT10  240
`define TXOFF_CRS_FX_BT10  220
`define TXEN_LINE_TP_BT10  53
`define TXEN_LINE_FX_BT10  50

// 10BASE-T link integrity
`define LINK_LOSS_MS       50
`define LINK_RX_MIN_MS     2
`define LINK_RX_MAX_MS     50
`define LINK_TX_PERIOD_MS  16
`define LINK_PULSE_W_NS    100
`define LINK_GOOD_PULSES   2

`endif

// ---- src/phy_timing_pkg.sv ----
// types shared by the mii timing logic
package phy_timing_pkg;

  // delayed actions, one delay line each
  typedef enum int {
    EV_RX_CRS_ON, EV_RX_DV_ON, EV_RX_CRS_OFF, EV_COL_ON, EV_COL_OFF,
    EV_TX_CRS_ON, EV_TX_CRS_OFF, EV_LINE_ON, EV_LINE_OFF, EV_COUNT
  } ev_t;

  typedef enum logic [0:0] {LI_SEARCH, LI_UP} link_state_t;

  // line decoder events and nibble, same clock as ref_clk
  typedef struct packed {
    logic       j_start;
    logic       t_start;
    logic [3:0] nibble;
  } line_rx_t;

  // mii receive side towards the mac
  typedef struct packed {
    logic       crs;
    logic       col;
    logic       rx_dv;
    logic [3:0] rxd;
  } mii_rx_t;

endpackage : phy_timing_pkg

// ---- src/event_delay.sv ----
// one programmable delay line: start, count, single cycle done
`timescale 1ns/1ns
module event_delay #(
  parameter int DLY_W = 6
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             start,
  input  wire logic [DLY_W-1:0] dly,
  output logic                  done
);

  logic [DLY_W-1:0] cnt_q;
  logic [DLY_W-1:0] cnt_d;

  if (DLY_W < 2) begin : g_bad_width
    $error("event_delay needs DLY_W of two or more");
  end

  // a new start restarts the count
  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = dly;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - DLY_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == DLY_W'(1));

endmodule : event_delay

// ---- src/link_integrity.sv ----
// 10BASE-T link pulse qualification, link loss and idle link pulse generation
`timescale 1ns/1ns
`include "phy_timing_regs.svh"
module link_integrity #(
  parameter int LOSS_CYC      = `MS_CYC(`LINK_LOSS_MS),
  parameter int RX_MIN_CYC    = `MS_CYC(`LINK_RX_MIN_MS),
  parameter int RX_MAX_CYC    = `MS_CYC(`LINK_RX_MAX_MS),
  parameter int TX_PERIOD_CYC = `MS_CYC(`LINK_TX_PERIOD_MS),
  parameter int PULSE_W_CYC   = `NS_CYC(`LINK_PULSE_W_NS),
  parameter int GOOD_PULSES   = `LINK_GOOD_PULSES,
  parameter int CNT_W         = 26
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic enable,
  input  wire logic lp_seen,
  input  wire logic activity,
  input  wire logic tx_busy,
  output logic      link_up,
  output logic      link_pulse_out
);

  phy_timing_pkg::link_state_t state_q, state_d;
  logic [CNT_W-1:0] gap_q, gap_d, per_q, per_d;
  logic [7:0]       pw_q, pw_d;
  logic [3:0]       good_q, good_d;
  logic             lp_prev_q, lp_rise, out_q, out_d;

  if (LOSS_CYC >= (1 << CNT_W) || TX_PERIOD_CYC >= (1 << CNT_W) || RX_MAX_CYC >= (1 << CNT_W) ||
      PULSE_W_CYC < 1 || PULSE_W_CYC > 255 || GOOD_PULSES < 1 || GOOD_PULSES > 15 ||
      RX_MIN_CYC >= RX_MAX_CYC) begin : g_bad_param
    $error("link_integrity parameters out of range");
  end

  assign lp_rise = lp_seen & ~lp_prev_q;

  // receive qualification and loss
  always_comb begin
    state_d = state_q;
    good_d  = good_q;
    gap_d   = (gap_q == '1) ? gap_q : gap_q + CNT_W'(1);
    if (lp_rise || (state_q == phy_timing_pkg::LI_UP && activity)) begin
      gap_d = '0;
    end
    case (state_q)
      phy_timing_pkg::LI_SEARCH: begin
        if (lp_rise) begin
          if (gap_q < CNT_W'(RX_MIN_CYC)) begin
            good_d = '0;
          end else if (good_q + 4'h1 >= 4'(GOOD_PULSES)) begin
            good_d  = '0;
            state_d = phy_timing_pkg::LI_UP;
          end else begin
            good_d = good_q + 4'h1;
          end
        end else if (gap_q >= CNT_W'(RX_MAX_CYC)) begin
          good_d = '0;
        end
      end
      phy_timing_pkg::LI_UP: begin
        if (!lp_rise && !activity && gap_q >= CNT_W'(LOSS_CYC)) begin
          state_d = phy_timing_pkg::LI_SEARCH;
        end
      end
      default: state_d = phy_timing_pkg::LI_SEARCH;
    endcase
    if (!enable) begin
      state_d = phy_timing_pkg::LI_SEARCH;
      good_d  = '0;
    end
  end

  // idle link pulses, held back while the transmitter is busy
  always_comb begin
    per_d = '0;
    pw_d  = (pw_q != '0) ? pw_q - 8'h01 : pw_q;
    if (enable && !tx_busy) begin
      per_d = per_q + CNT_W'(1);
      if (per_q == CNT_W'(TX_PERIOD_CYC - 1)) begin
        per_d = '0;
        pw_d  = 8'(PULSE_W_CYC);
      end
    end
    out_d = (pw_d != '0);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= phy_timing_pkg::LI_SEARCH;
      good_q    <= '0;
      gap_q     <= '0;
      per_q     <= '0;
      pw_q      <= '0;
      out_q     <= 1'h0;
      lp_prev_q <= 1'h0;
    end else begin
      state_q   <= state_d;
      good_q    <= good_d;
      gap_q     <= gap_d;
      per_q     <= per_d;
      pw_q      <= pw_d;
      out_q     <= out_d;
      lp_prev_q <= lp_seen;
    end
  end

  assign link_up        = (state_q == phy_timing_pkg::LI_UP);
  assign link_pulse_out = out_q;

  a_link_loss_time: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (enable && $fell(link_up)) |-> $past(gap_q) >= CNT_W'(LOSS_CYC))
    else $error("link dropped before the loss time");
  a_short_pulse_rst: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (enable && !link_up && lp_rise && gap_q < CNT_W'(RX_MIN_CYC)) |=> (good_q == '0) && !link_up)
    else $error("too early link pulse was counted");
  a_long_gap_rst: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (enable && !link_up && !lp_rise && gap_q >= CNT_W'(RX_MAX_CYC)) |=> good_q == '0)
    else $error("pulse count kept across a long gap");
  a_link_qualify: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(link_up) |-> $past(good_q) == 4'(GOOD_PULSES - 1) && $past(lp_rise))
    else $error("link up without enough valid pulses");
  a_pulse_idle_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(link_pulse_out) |-> $past(enable && !tx_busy, 2))
    else $error("link pulse started while transmitting");

endmodule : link_integrity

// ---- dv/mac_model.sv ----
// mac side model: drives transmit enable on tx_clk
`timescale 1ns/1ns
module mac_model (
  input  wire logic tx_clk,
  input  wire logic rst_b,
  input  wire logic send,
  input  wire logic crs,
  output logic      tx_en
);
  // a frame starts only on a quiet medium and runs while asked
  always_ff @(posedge tx_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_en <= 1'b0;
    end else begin
      tx_en <= send & (tx_en | ~crs);
    end
  end
endmodule : mac_model

// ---- dv/phy_mii_carrier_link_timing_bench.sv ----
// self-checking bench of carrier, collision, latency and link timing
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module phy_mii_carrier_link_timing_bench;
  logic ref_clk = 0, tx_clk = 0, rst_b = 0, send = 0, mode_fx = 0, mode_10bt = 0, lp_in = 0, fdx = 0, act = 0;
  logic tx_en, line_out, lp_out, link_up;
  phy_timing_pkg::line_rx_t line_rx = '{1'b0, 1'b0, 4'hA};
  phy_timing_pkg::mii_rx_t  mii_rx;
  int num_errors = 0, comparisons = 0, n;

  // short link timers keep the run brief
  phy_mii_carrier_link_timing #(.LOSS_CYC(2000), .RX_MIN_CYC(200), .RX_MAX_CYC(2000), .TX_PERIOD_CYC(300)) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .tx_clk(tx_clk), .tx_en(tx_en), .mode_fx(mode_fx),
    .mode_10bt(mode_10bt), .full_duplex(fdx), .line_rx(line_rx), .link_pulse_in(lp_in),
    .rx_activity(act), .mii_rx(mii_rx), .line_transmit_output(line_out), .link_pulse_out(lp_out),
    .link_up(link_up));
  mac_model i_mac (.tx_clk(tx_clk), .rst_b(rst_b), .send(send), .crs(mii_rx.crs), .tx_en(tx_en));

  // clocks of the two domains
  initial forever #2 ref_clk = ~ref_clk;
  initial forever begin
    #7 tx_clk = 1'b1;
    #8 tx_clk = 1'b0;
  end

  // watched outputs by number
  function automatic logic sig(int k);
    case (k)
      0: return mii_rx.crs;
      1: return mii_rx.col;
      2: return mii_rx.rx_dv;
      3: return line_out;
      4: return link_up;
      5: return lp_out;
      default: return tx_en;
    endcase
  endfunction : sig

  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // counts falling edges until an output reaches v, then judges the count
  task automatic span(string nm, int k, logic v, int lo, int hi, bit keep = 0);
    if (!keep) n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (sig(k) !== v && n < 3000);
    if (n >= 3000) begin
      num_errors++;
      summarize();
    end
    `CHK(nm, 1'b1, n >= lo && n <= hi)
  endtask : span

  // one cycle start (j) or end (t) delimiter, returns on the taking edge
  task automatic mark(logic j);
    @(posedge ref_clk);
    line_rx.j_start <= j;
    line_rx.t_start <= !j;
    @(posedge ref_clk);
    line_rx.j_start <= 1'b0;
    line_rx.t_start <= 1'b0;
  endtask : mark

  task automatic rx_frame(logic fx);
    @(posedge ref_clk);
    mode_fx <= fx;
    repeat (6) @(posedge ref_clk);
    mark(1'b1);
    span("crs_on", 0, 1'b1, 30, 40);
    span("dv_on", 2, 1'b1, 8, 12);
    `CHK("rxd", 4'hA, mii_rx.rxd)
    repeat (20) @(posedge ref_clk);
    mark(1'b0);
    if (fx) span("crs_off", 0, 1'b0, 40, 55);
    else span("crs_off", 0, 1'b0, 25, 42);
  endtask : rx_frame

  task automatic col_frame(logic fx);
    @(posedge ref_clk);
    mode_fx <= fx;
    send    <= 1'b1;
    repeat (80) @(posedge ref_clk);
    mark(1'b1);
    if (fx) span("col_on", 1, 1'b1, 25, 37);
    else span("col_on", 1, 1'b1, 40, 55);
    repeat (30) @(posedge ref_clk);
    mark(1'b0);
    if (fx) span("col_off", 1, 1'b0, 35, 45);
    else span("col_off", 1, 1'b0, 43, 50);
    send <= 1'b0;
    repeat (120) @(posedge ref_clk);
  endtask : col_frame

  // full duplex: reception overlapping transmission raises no collision
  task automatic fdx_frame();
    @(posedge ref_clk);
    fdx  <= 1'b1;
    send <= 1'b1;
    repeat (80) @(posedge ref_clk);
    mark(1'b1);
    repeat (60) @(negedge ref_clk);
    `CHK("fdx_col", 1'b0, mii_rx.col)
    mark(1'b0);
    send <= 1'b0;
    fdx  <= 1'b0;
    repeat (120) @(posedge ref_clk);
  endtask : fdx_frame

  // counted from the mac's tx_en edge: one tx_clk period to the sampling edge, synchronising and observing come to 5 or 6 cycles,
  // so the line_on window is the delay in cycles plus 5 low and plus 6 high; the crs windows are plus 5 low and 11 to 16 high
  task automatic tx_frame(logic fx);
    @(posedge ref_clk);
    mode_fx <= fx;
    repeat (6) @(posedge ref_clk);
    send <= 1'b1;
    span("tx_on", 6, 1'b1, 1, 8);
    if (fx) span("line_on", 3, 1'b1, 18, 19);
    else span("line_on", 3, 1'b1, 19, 20);
    if (fx) span("crs_on", 0, 1'b1, 48, 56, 1);
    else span("crs_on", 0, 1'b1, 55, 66, 1);
    send <= 1'b0;
    span("tx_off", 6, 1'b0, 1, 8);
    if (fx) span("crs_off", 0, 1'b0, 60, 66);
    else span("crs_off", 0, 1'b0, 65, 76);
    repeat (30) @(posedge ref_clk);
  endtask : tx_frame

  task automatic lpulse();
    @(posedge ref_clk);
    lp_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    lp_in <= 1'b0;
  endtask : lpulse

  task automatic link_check();
    @(posedge ref_clk);
    mode_10bt <= 1'b1;
    span("lp_on", 5, 1'b1, 1, 320);
    span("lp_width", 5, 1'b0, 15, 37);
    lpulse();
    repeat (300) @(posedge ref_clk);
    lpulse();
    span("link_up", 4, 1'b1, 1, 10);
    // receive activity half way restarts the loss time
    repeat (1000) @(posedge ref_clk);
    act <= 1'b1;
    @(posedge ref_clk);
    act <= 1'b0;
    span("link_loss", 4, 1'b0, 1900, 2010);
    lpulse();
    repeat (50) @(posedge ref_clk);
    lpulse();
    repeat (20) @(negedge ref_clk);
    `CHK("early_pulse", 1'b0, link_up)
    mode_10bt <= 1'b0;
  endtask : link_check

  // reset, then receive, collision and transmit scenarios in both media modes, then full duplex and link once
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    for (int fx = 0; fx < 2; fx++) begin
      rx_frame(fx[0]);
      col_frame(fx[0]);
      tx_frame(fx[0]);
    end
    fdx_frame();
    link_check();
    summarize();
  end
endmodule : phy_mii_carrier_link_timing_bench
